//--- arc_audio_route_and_dac_ctrl.sv
// control registers, stream routing and playback converter digital control
`timescale 1ns/10ps
`include "arc_cfg.svh"
module arc_audio_route_and_dac_ctrl #(
    parameter int SAMPLE_W = 24
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      clkEn,
    input  wire logic                      regWrite,
    input  wire logic                      regRead,
    input  wire logic [`ARC_ADDR_W-1:0]    regAddr,
    input  wire logic [7:0]                regWdata,
    output logic      [7:0]                regRdata,
    input  wire logic                      sampleStrobe,
    input  wire logic [SAMPLE_W-1:0]       adcLeft,
    input  wire logic [SAMPLE_W-1:0]       adcRight,
    input  wire logic [SAMPLE_W-1:0]       rxLeft,
    input  wire logic [SAMPLE_W-1:0]       rxRight,
    input  wire logic [SAMPLE_W-1:0]       playLeft,
    input  wire logic [SAMPLE_W-1:0]       playRight,
    input  wire logic [SAMPLE_W-1:0]       auxInLeft,
    input  wire logic [SAMPLE_W-1:0]       auxInRight,
    input  wire logic [SAMPLE_W-1:0]       rateOutLeft,
    input  wire logic [SAMPLE_W-1:0]       rateOutRight,
    input  wire logic                      leftVolZero,
    input  wire logic                      rightVolZero,
    output logic      [SAMPLE_W-1:0]       rateInLeft,
    output logic      [SAMPLE_W-1:0]       rateInRight,
    output logic      [SAMPLE_W-1:0]       recordLeft,
    output logic      [SAMPLE_W-1:0]       recordRight,
    output logic      [SAMPLE_W-1:0]       auxOutLeft,
    output logic      [SAMPLE_W-1:0]       auxOutRight,
    output logic      [SAMPLE_W-1:0]       txLeft,
    output logic      [SAMPLE_W-1:0]       txRight,
    output logic      [SAMPLE_W-1:0]       dacLeft,
    output logic      [SAMPLE_W-1:0]       dacRight,
    output logic                           dacPowerDown,
    output logic                           dacOutputGround,
    output logic                           dacDigitalReset,
    output logic                           dacClockTick,
    output arc_pkg::arc_interp_t           interpRatio,
    output arc_pkg::arc_deemph_t           deemphasisSel,
    output logic                           zeroFlagLeft,
    output logic                           zeroFlagRight
);
    generate
        if (SAMPLE_W < 2) begin : g_check
            $error("SAMPLE_W must be at least 2");
        end
    endgenerate

    logic [7:0] streamRoutingOne;
    logic [7:0] streamRoutingTwo;
    logic [7:0] playbackConvControlOne;
    logic [7:0] playbackConvControlTwo;
    logic [7:0] playbackZeroFlagControl;

    // configuration registers; the converter digital reset leaves them alone
    always_ff @(posedge clock) begin
        if (rst) begin
            streamRoutingOne        <= `ARC_RST_ROUTE_ONE;
            streamRoutingTwo        <= `ARC_RST_ROUTE_TWO;
            playbackConvControlOne  <= `ARC_RST_CONV_ONE;
            playbackConvControlTwo  <= `ARC_RST_CONV_TWO;
            playbackZeroFlagControl <= `ARC_RST_ZFLAG;
        end else if (clkEn && regWrite) begin
            unique case (regAddr)
                `ARC_OFF_ROUTE_ONE: streamRoutingOne <= regWdata;
                `ARC_OFF_ROUTE_TWO: streamRoutingTwo <= regWdata & `ARC_MASK_ROUTE_TWO;
                `ARC_OFF_CONV_ONE:  playbackConvControlOne <= regWdata;
                `ARC_OFF_CONV_TWO:  playbackConvControlTwo <= regWdata & `ARC_MASK_CONV_TWO;
                `ARC_OFF_ZFLAG:     playbackZeroFlagControl <= regWdata & `ARC_MASK_ZFLAG;
                default: ;
            endcase
        end
    end

    // read data, reserved bits and unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (clkEn && regRead) begin
            unique case (regAddr)
                `ARC_OFF_ROUTE_ONE: regRdata <= streamRoutingOne;
                `ARC_OFF_ROUTE_TWO: regRdata <= streamRoutingTwo;
                `ARC_OFF_CONV_ONE:  regRdata <= playbackConvControlOne;
                `ARC_OFF_CONV_TWO:  regRdata <= playbackConvControlTwo;
                `ARC_OFF_ZFLAG:     regRdata <= playbackZeroFlagControl;
                default:            regRdata <= 8'h00;
            endcase
        end
    end

    // field decode
    logic [1:0] rateConvInputSel;
    logic [2:0] recordOutSel;
    logic [2:0] auxOutSel;
    logic [2:0] dacSourceSel;
    logic [2:0] spdifTxSourceSel;
    logic       fullResetPowerdown;
    logic       digitalLogicReset;
    logic [1:0] channelMap;
    logic [1:0] channelInvert;
    logic       rightMuteN;
    logic       leftMuteN;
    logic [1:0] masterClockDivide;
    logic       zflagMuteVolDisable;
    logic       zflagZeroDataDisable;
    logic       zflagPolarity;
    logic       convHeld;

    assign rateConvInputSel     = streamRoutingOne[`ARC_POS_RATE_SEL +: 2];
    assign recordOutSel         = streamRoutingOne[`ARC_POS_REC_SEL +: 3];
    assign auxOutSel            = streamRoutingOne[`ARC_POS_AUX_SEL +: 3];
    assign dacSourceSel         = streamRoutingTwo[`ARC_POS_DAC_SEL +: 3];
    assign spdifTxSourceSel     = streamRoutingTwo[`ARC_POS_TX_SEL +: 3];
    assign fullResetPowerdown   = playbackConvControlOne[`ARC_POS_FULL_RST];
    assign digitalLogicReset    = playbackConvControlOne[`ARC_POS_DIG_RST];
    assign channelMap           = playbackConvControlOne[`ARC_POS_CHMAP +: 2];
    assign channelInvert        = playbackConvControlOne[`ARC_POS_INVERT +: 2];
    assign rightMuteN           = playbackConvControlOne[`ARC_POS_MUTE_R];
    assign leftMuteN            = playbackConvControlOne[`ARC_POS_MUTE_L];
    assign masterClockDivide    = playbackConvControlTwo[`ARC_POS_MCLK_DIV +: 2];
    assign zflagMuteVolDisable  = playbackZeroFlagControl[`ARC_POS_ZF_VOL];
    assign zflagZeroDataDisable = playbackZeroFlagControl[`ARC_POS_ZF_DATA];
    assign zflagPolarity        = playbackZeroFlagControl[`ARC_POS_ZF_POL];

    // converter power and reset state
    assign convHeld        = fullResetPowerdown | digitalLogicReset;
    assign dacPowerDown    = fullResetPowerdown;
    assign dacOutputGround = fullResetPowerdown;
    assign dacDigitalReset = convHeld;
    assign interpRatio     = arc_pkg::arc_interp_t'(playbackConvControlTwo[`ARC_POS_INTERP +: 2]);
    assign deemphasisSel   = arc_pkg::arc_deemph_t'(playbackConvControlTwo[`ARC_POS_DEEMPH +: 2]);

    // one stereo pair per source code; codes above 100 give silence
    function automatic logic [2*SAMPLE_W-1:0] pick(input logic [2:0] sel);
        unique case (arc_pkg::arc_source_t'(sel))
            arc_pkg::ARC_SRC_ADC:  pick = {adcLeft, adcRight};
            arc_pkg::ARC_SRC_RX:   pick = {rxLeft, rxRight};
            arc_pkg::ARC_SRC_PLAY: pick = {playLeft, playRight};
            arc_pkg::ARC_SRC_AUX:  pick = {auxInLeft, auxInRight};
            arc_pkg::ARC_SRC_RATE: pick = {rateOutLeft, rateOutRight};
            default:               pick = '0;
        endcase
    endfunction

    // routing of the four output streams on each sample strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            rateInLeft  <= '0;
            rateInRight <= '0;
            recordLeft  <= '0;
            recordRight <= '0;
            auxOutLeft  <= '0;
            auxOutRight <= '0;
            txLeft      <= '0;
            txRight     <= '0;
        end else if (clkEn && sampleStrobe) begin
            {rateInLeft, rateInRight}   <= pick({1'b0, rateConvInputSel});
            {recordLeft, recordRight}   <= pick(recordOutSel);
            {auxOutLeft, auxOutRight}   <= pick(auxOutSel);
            {txLeft, txRight}           <= pick(spdifTxSourceSel);
        end
    end

    // playback converter channel map, polarity and mute
    logic [SAMPLE_W-1:0] srcL;
    logic [SAMPLE_W-1:0] srcR;
    logic [SAMPLE_W-1:0] mapL;
    logic [SAMPLE_W-1:0] mapR;
    logic [SAMPLE_W-1:0] next_dacLeft;
    logic [SAMPLE_W-1:0] next_dacRight;

    always_comb begin
        {srcL, srcR} = pick(dacSourceSel);
        unique case (arc_pkg::arc_chmap_t'(channelMap))
            arc_pkg::ARC_MAP_NORMAL: {mapL, mapR} = {srcL, srcR};
            arc_pkg::ARC_MAP_RIGHT:  {mapL, mapR} = {srcR, srcR};
            arc_pkg::ARC_MAP_LEFT:   {mapL, mapR} = {srcL, srcL};
            arc_pkg::ARC_MAP_SWAP:   {mapL, mapR} = {srcR, srcL};
        endcase
        next_dacLeft  = channelInvert[0] ? SAMPLE_W'(-mapL) : mapL;
        next_dacRight = channelInvert[1] ? SAMPLE_W'(-mapR) : mapR;
        if (!leftMuteN) begin
            next_dacLeft = '0;
        end
        if (!rightMuteN) begin
            next_dacRight = '0;
        end
    end

    // converter samples; held at zero while the converter is in reset
    always_ff @(posedge clock) begin
        if (rst) begin
            dacLeft  <= '0;
            dacRight <= '0;
        end else if (clkEn) begin
            if (convHeld) begin
                dacLeft  <= '0;
                dacRight <= '0;
            end else if (sampleStrobe) begin
                dacLeft  <= next_dacLeft;
                dacRight <= next_dacRight;
            end
        end
    end

    // master clock divider: tick pattern per period, 1.5 gives two ticks in three
    logic [1:0] divCount;
    logic       divPeriod3;
    assign divPeriod3 = masterClockDivide[0];
    always_comb begin
        unique case (arc_pkg::arc_mclk_div_t'(masterClockDivide))
            arc_pkg::ARC_DIV_1:   dacClockTick = !convHeld;
            arc_pkg::ARC_DIV_1P5: dacClockTick = !convHeld && divCount != `ARC_DIV_PERIOD3;
            arc_pkg::ARC_DIV_2:   dacClockTick = !convHeld && divCount[0];
            arc_pkg::ARC_DIV_3:   dacClockTick = !convHeld && divCount == `ARC_DIV_PERIOD3;
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            divCount <= 2'h0;
        end else if (clkEn) begin
            if (convHeld) begin
                divCount <= 2'h0;
            end else if (divPeriod3 && divCount == `ARC_DIV_PERIOD3) begin
                divCount <= 2'h0;
            end else if (!divPeriod3) begin
                divCount <= {1'b0, ~divCount[0]};
            end else begin
                divCount <= divCount + 2'h1;
            end
        end
    end

    // zero flags from sample data and from mute or zero volume
    logic zeroLeft;
    logic zeroRight;
    always_comb begin
        zeroLeft  = (!zflagZeroDataDisable && dacLeft == '0)
                  || (!zflagMuteVolDisable && (!leftMuteN || leftVolZero));
        zeroRight = (!zflagZeroDataDisable && dacRight == '0)
                  || (!zflagMuteVolDisable && (!rightMuteN || rightVolZero));
    end
    assign zeroFlagLeft  = zflagPolarity ? zeroLeft : !zeroLeft;
    assign zeroFlagRight = zflagPolarity ? zeroRight : !zeroRight;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_rate_in_route: assert property (clkEn && sampleStrobe && rateConvInputSel == 2'b01 |=> rateInLeft == $past(rxLeft))
        else $error("rate converter input not from receiver");
    a_record_route: assert property (clkEn && sampleStrobe && recordOutSel == 3'b100 |=> recordRight == $past(rateOutRight))
        else $error("record output not from rate converter");
    a_aux_route: assert property (clkEn && sampleStrobe && auxOutSel == 3'b011 |=> auxOutLeft == $past(auxInLeft))
        else $error("aux output not from aux input");
    a_tx_route: assert property (clkEn && sampleStrobe && spdifTxSourceSel == 3'b010 |=> txRight == $past(playRight))
        else $error("transmitter not from playback");
    a_held_silent: assert property (clkEn && convHeld |=> dacLeft == '0 && dacRight == '0 && (!convHeld || !dacClockTick))
        else $error("converter active while held");
    a_dig_reset_regs: assert property (clkEn && digitalLogicReset && !regWrite |=> $stable(playbackConvControlTwo))
        else $error("digital reset touched registers");
    a_swap_map: assert property (clkEn && sampleStrobe && !convHeld && channelMap == 2'b11
            && channelInvert == 2'b00 && leftMuteN && rightMuteN && dacSourceSel == 3'b000 |=> dacLeft == $past(adcRight))
        else $error("swap map wrong");
    a_left_invert: assert property (clkEn && sampleStrobe && !convHeld && channelMap == 2'b00
            && channelInvert == 2'b01 && leftMuteN && dacSourceSel == 3'b000 |=> dacLeft == SAMPLE_W'(-$past(adcLeft)))
        else $error("left inversion wrong");
    a_mute_zero: assert property (clkEn && sampleStrobe && !leftMuteN |=> dacLeft == '0)
        else $error("muted left not silent");
    a_div3_tick: assert property (clkEn && !convHeld && masterClockDivide == 2'b11 && dacClockTick
            ##1 (clkEn && masterClockDivide == 2'b11 && !convHeld) |-> !dacClockTick)
        else $error("divide by three ticks too often");
    a_zflag_mute: assert property (!zflagMuteVolDisable && !leftMuteN |-> zeroFlagLeft == zflagPolarity)
        else $error("mute did not raise zero flag");
    a_zflag_data: assert property (zflagZeroDataDisable && zflagMuteVolDisable |-> zeroFlagRight == !zflagPolarity)
        else $error("disabled zero flag asserted");
    a_interp_out: assert property (clkEn && regWrite && regAddr == `ARC_OFF_CONV_TWO
            |=> interpRatio == $past(regWdata[3:2]) && deemphasisSel == $past(regWdata[1:0]))
        else $error("interpolator or de-emphasis mismatch");

    c_swap_run: cover property (clkEn && sampleStrobe && channelMap == 2'b11 && !convHeld);
    c_full_reset: cover property (clkEn && fullResetPowerdown ##1 clkEn && !fullResetPowerdown);
    c_div_1p5: cover property (masterClockDivide == 2'b01 && dacClockTick ##1 dacClockTick);
    c_zero_flag: cover property (zeroFlagLeft == zflagPolarity && zflagPolarity);
endmodule

//--- arc_cfg.svh
// register map, field positions, reset values and codes of the route and playback control block
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH
`define ARC_ADDR_W          7
`define ARC_OFF_ROUTE_ONE   7'h62
`define ARC_OFF_ROUTE_TWO   7'h63
`define ARC_OFF_CONV_ONE    7'h64
`define ARC_OFF_CONV_TWO    7'h65
`define ARC_OFF_ZFLAG       7'h66
`define ARC_RST_ROUTE_ONE   8'h00
`define ARC_RST_ROUTE_TWO   8'h00
`define ARC_RST_CONV_ONE    8'h00
`define ARC_RST_CONV_TWO    8'h00
`define ARC_RST_ZFLAG       8'h00
`define ARC_MASK_ROUTE_TWO  8'h3F
`define ARC_MASK_CONV_TWO   8'h3F
`define ARC_MASK_ZFLAG      8'h07
`define ARC_POS_RATE_SEL    6
`define ARC_POS_REC_SEL     3
`define ARC_POS_AUX_SEL     0
`define ARC_POS_DAC_SEL     3
`define ARC_POS_TX_SEL      0
`define ARC_POS_FULL_RST    7
`define ARC_POS_DIG_RST     6
`define ARC_POS_CHMAP       4
`define ARC_POS_INVERT      2
`define ARC_POS_MUTE_R      1
`define ARC_POS_MUTE_L      0
`define ARC_POS_MCLK_DIV    4
`define ARC_POS_INTERP      2
`define ARC_POS_DEEMPH      0
`define ARC_POS_ZF_VOL      2
`define ARC_POS_ZF_DATA     1
`define ARC_POS_ZF_POL      0
`define ARC_DIV_PERIOD3     2'h2
`endif

//--- arc_pkg.sv
// types of the route and playback control block
package arc_pkg;
    typedef enum logic [2:0] {
        ARC_SRC_ADC  = 3'b000,
        ARC_SRC_RX   = 3'b001,
        ARC_SRC_PLAY = 3'b010,
        ARC_SRC_AUX  = 3'b011,
        ARC_SRC_RATE = 3'b100
    } arc_source_t;
    typedef enum logic [1:0] {
        ARC_MAP_NORMAL = 2'b00,
        ARC_MAP_RIGHT  = 2'b01,
        ARC_MAP_LEFT   = 2'b10,
        ARC_MAP_SWAP   = 2'b11
    } arc_chmap_t;
    typedef enum logic [1:0] {
        ARC_DIV_1   = 2'b00,
        ARC_DIV_1P5 = 2'b01,
        ARC_DIV_2   = 2'b10,
        ARC_DIV_3   = 2'b11
    } arc_mclk_div_t;
    typedef enum logic [1:0] {
        ARC_INTERP_8X = 2'b00,
        ARC_INTERP_4X = 2'b01,
        ARC_INTERP_2X = 2'b10,
        ARC_INTERP_RSV = 2'b11
    } arc_interp_t;
    typedef enum logic [1:0] {
        ARC_DEEM_NONE = 2'b00,
        ARC_DEEM_44K1 = 2'b01,
        ARC_DEEM_32K  = 2'b10,
        ARC_DEEM_48K  = 2'b11
    } arc_deemph_t;
endpackage

//--- tb_arc_audio_route_and_dac_ctrl.sv
// self-checking testbench of the route and playback control block
`timescale 1ns/10ps
module tb_arc_audio_route_and_dac_ctrl;
    localparam int W = 24;
    logic                 clock = 1'b0;
    logic                 rst = 1'b1;
    logic                 clkEn = 1'b1;
    logic                 regWrite = 1'b0;
    logic                 regRead = 1'b0;
    logic [6:0]           regAddr = 7'h00;
    logic [7:0]           regWdata = 8'h00;
    logic [7:0]           regRdata;
    logic                 sampleStrobe = 1'b0;
    logic [W-1:0]         src [10];
    logic [W-1:0]         outs [10];
    logic                 leftVolZero = 1'b0;
    logic                 rightVolZero = 1'b0;
    logic                 dacPowerDown;
    logic                 dacOutputGround;
    logic                 dacDigitalReset;
    logic                 dacClockTick;
    logic                 zeroFlagLeft;
    logic                 zeroFlagRight;
    arc_pkg::arc_interp_t interpRatio;
    arc_pkg::arc_deemph_t deemphasisSel;
    int                   mismatches = 0;
    int                   n_checks = 0;
    int                   seed = 57178;
    int                   cycles = 0;

    arc_audio_route_and_dac_ctrl #(.SAMPLE_W(W)) i_dut (
        .clock(clock), .rst(rst), .clkEn(clkEn), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .sampleStrobe(sampleStrobe),
        .adcLeft(src[0]), .adcRight(src[1]), .rxLeft(src[2]), .rxRight(src[3]),
        .playLeft(src[4]), .playRight(src[5]), .auxInLeft(src[6]), .auxInRight(src[7]),
        .rateOutLeft(src[8]), .rateOutRight(src[9]),
        .leftVolZero(leftVolZero), .rightVolZero(rightVolZero),
        .rateInLeft(outs[0]), .rateInRight(outs[1]), .recordLeft(outs[2]), .recordRight(outs[3]),
        .auxOutLeft(outs[4]), .auxOutRight(outs[5]), .txLeft(outs[6]), .txRight(outs[7]),
        .dacLeft(outs[8]), .dacRight(outs[9]), .dacPowerDown(dacPowerDown),
        .dacOutputGround(dacOutputGround), .dacDigitalReset(dacDigitalReset),
        .dacClockTick(dacClockTick), .interpRatio(interpRatio), .deemphasisSel(deemphasisSel),
        .zeroFlagLeft(zeroFlagLeft), .zeroFlagRight(zeroFlagRight));

    // clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    // compare, count and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // inputs move 1 ns after the rising edge
    task automatic step();
        @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        step();
        regWrite = 1'b0;
        step(); // one idle edge so a following write raises the strobe afresh
    endtask

    // read data is registered, so it is looked at one edge after the strobe
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        regRead = 1'b1;
        regAddr = a;
        step();
        regRead = 1'b0;
        check(regRdata, exp);
        step(); // one idle edge between reads
    endtask

    // fresh random samples, a quarter of them zero, then one strobe
    task automatic strobe();
        for (int k = 0; k < 10; k++) src[k] = (($random(seed) & 3) == 0) ? '0 : W'($random(seed));
        leftVolZero = 1'($random(seed));
        rightVolZero = 1'($random(seed));
        sampleStrobe = 1'b1;
        step();
        sampleStrobe = 1'b0;
    endtask

    // source sample for a selector code, zero for unused codes
    function automatic logic [W-1:0] pick(input logic [2:0] c, input int r);
        return (c > 3'd4) ? '0 : src[2 * c + r];
    endfunction

    // converter sample from the analog input after map, invert and mute
    function automatic logic [W-1:0] exp_dac(input logic [5:0] c, input int r);
        logic [W-1:0] v;
        v = src[r ? !c[5] : c[4]];
        if (c[2 + r]) v = -v;
        if (!c[r]) v = '0;
        return v;
    endfunction

    function automatic logic zf(input logic [5:0] c, input logic [2:0] z, input int r, input logic vz);
        logic act;
        act = (exp_dac(c, r) == '0 && !z[1]) || ((!c[r] || vz) && !z[2]);
        return z[0] ? act : !act;
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial begin
        logic [7:0] d;
        logic [2:0] z;
        int         cnt;
        int         divTicks [4];
        logic [7:0] masks [5];
        divTicks = '{12, 8, 6, 4};
        masks = '{8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'h07};
        for (int k = 0; k < 10; k++) src[k] = '0;
        repeat (8) step();
        rst = 1'b0;
        // reset values, unmapped neighbours read zero
        for (int a = 'h61; a <= 'h67; a++) rd(7'(a), 8'h00);
        check(zeroFlagLeft, 1'b0);
        check(dacPowerDown, 1'b0);
        check(dacClockTick, 1'b1);
        $display("test reset done");
        // register write and read back with reserved bits dropped
        for (int i = 0; i < 20; i++) begin
            d = 8'($random(seed));
            wr(7'(8'h62 + i % 5), d);
            rd(7'(8'h62 + i % 5), d & masks[i % 5]);
        end
        wr(7'h67, 8'hA5);
        rd(7'h67, 8'h00);
        wr(7'h66, 8'h05);
        clkEn = 1'b0;
        wr(7'h66, 8'h02);
        clkEn = 1'b1;
        rd(7'h66, 8'h05);
        $display("test registers done");
        // every selector code, unused codes give zero
        for (int i = 0; i < 8; i++) begin
            wr(7'h62, {i[1:0], i[2:0], i[2:0]});
            wr(7'h63, {2'b00, i[2:0], i[2:0]});
            wr(7'h64, 8'h03);
            strobe();
            for (int r = 0; r < 2; r++) begin
                check(outs[r], pick({1'b0, i[1:0]}, r));
                check(outs[2 + r], pick(i[2:0], r));
                check(outs[4 + r], pick(i[2:0], r));
                check(outs[6 + r], pick(i[2:0], r));
                check(outs[8 + r], pick(i[2:0], r));
            end
        end
        $display("test routing done");
        // all map, invert and mute settings with random flag controls
        wr(7'h63, 8'h00);
        for (int i = 0; i < 64; i++) begin
            z = 3'($random(seed));
            wr(7'h64, {2'b00, i[5:0]});
            wr(7'h66, {5'b00000, z});
            strobe();
            check(outs[8], exp_dac(i[5:0], 0));
            check(outs[9], exp_dac(i[5:0], 1));
            check(zeroFlagLeft, zf(i[5:0], z, 0, leftVolZero));
            check(zeroFlagRight, zf(i[5:0], z, 1, rightVolZero));
        end
        $display("test converter path done");
        // full reset, then digital reset, then release
        wr(7'h64, 8'h83);
        check({dacPowerDown, dacOutputGround, dacDigitalReset, dacClockTick}, 4'b1110);
        strobe();
        check(outs[8], '0);
        wr(7'h64, 8'h43);
        check({dacPowerDown, dacOutputGround, dacDigitalReset, dacClockTick}, 4'b0010);
        strobe();
        check(outs[9], '0);
        wr(7'h64, 8'h03);
        check(dacDigitalReset, 1'b0);
        strobe();
        check(outs[8], src[0]);
        $display("test converter reset done");
        // divider tick counts, interpolator and de-emphasis codes
        for (int dv = 0; dv < 4; dv++) begin
            for (int f = 0; f < 4; f++) begin
                wr(7'h65, {2'b00, dv[1:0], f[1:0], f[1:0]});
                check(interpRatio, f);
                check(deemphasisSel, f);
                cnt = 0;
                repeat (12) begin
                    if (dacClockTick === 1'b1) cnt++;
                    step();
                end
                check(cnt, divTicks[dv]);
            end
        end
        $display("test divider done");
        close_out();
    end
endmodule
